// ==== conv_encoder_punct.sv ====
// rate 1/3 constraint 7 convolutional encoder with puncturing masks
// assumes the feeding logic flags the first bit of each encoded section
`timescale 1ns/1ps
`include "ofdm_tx_params.svh"

module conv_encoder_punct
  import ofdm_tx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire code_rate_t rate,
  input  wire logic       firstBit,
  input  wire logic       isPayload,
  input  wire logic       inValid,
  input  wire logic       inBit,
  output logic            inReady,
  output logic            outValid,
  input  wire logic       outReady,
  output coded_t          outData
);

  // ==================================================
  // pattern tables
  function automatic logic [14:0] puncMask(input code_rate_t r);
    unique case (r)
      RATE_THIRD:        puncMask = `PUNC_THIRD_MASK;
      RATE_HALF:         puncMask = `PUNC_HALF_MASK;
      RATE_FIVE_EIGHTHS: puncMask = `PUNC_58_MASK;
      RATE_THREE_QUARTERS: puncMask = `PUNC_34_MASK;
    endcase
  endfunction

  function automatic logic [2:0] puncLast(input code_rate_t r);
    unique case (r)
      RATE_THIRD:        puncLast = `PUNC_THIRD_LAST;
      RATE_HALF:         puncLast = `PUNC_HALF_LAST;
      RATE_FIVE_EIGHTHS: puncLast = `PUNC_58_LAST;
      RATE_THREE_QUARTERS: puncLast = `PUNC_34_LAST;
    endcase
  endfunction

  logic [5:0] state;
  logic [2:0] pos;

  // ==================================================
  // coding
  // the first bit of a section codes from the zero state, so no idle cycle is lost
  wire logic [5:0]  curState = firstBit ? 6'h00 : state;
  wire logic [2:0]  curPos   = firstBit ? 3'h0 : pos;
  wire logic [6:0]  taps     = {inBit, curState};
  wire logic [2:0]  coded    = {^(taps & `GEN_C), ^(taps & `GEN_B), ^(taps & `GEN_A)};
  wire logic [14:0] maskShift = puncMask(rate) >> ({1'b0, curPos} * 4'h3);
  // per input masking: a partial final block simply gets the leading part of the pattern
  wire logic [2:0]  keep     = maskShift[2:0];
  wire logic        take     = inValid & inReady;
  wire logic [2:0]  nextPos  = (curPos == puncLast(rate)) ? 3'h0 : curPos + 3'h1;

  assign inReady = ~outValid | outReady;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= 6'h00;
      pos   <= 3'h0;
    end else if (take) begin
      state <= {inBit, curState[5:1]};
      pos   <= nextPos;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      outValid <= 1'b0;
      outData  <= '0;
    end else if (take) begin
      outValid <= 1'b1;
      outData  <= '{bits: coded, keep: keep, payload: isPayload};
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end

endmodule

// ==== link_ctrl_model.sv ====
// link layer controller model: streams header, parity, payload and fcs bits
// assumes the encoder's inReady handshake on the shared rising clock
`timescale 1ns/1ps

module link_ctrl_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        go,
  input  wire logic [11:0] length,
  input  wire logic [1:0]  seedSelect,
  input  wire logic        inReady,
  output logic             inValid,
  output logic             inBit,
  output logic             inLast
);
  logic active = 1'b0;
  logic flip   = 1'b0;
  int   idx    = 0;
  int   total  = 0;

  function automatic logic srcBit(input int k);
    return ((k * 7) % 5) > 1;
  endfunction

  // ==================================================
  // 8 phy, 8 mac, 8 parity bits, then 8*length payload and 32 fcs bits when length is nonzero
  always @(posedge clk) begin
    flip <= ~flip;
    if (!nrst) begin
      active <= 1'b0;
      idx    <= 0;
    end else if (go) begin
      active <= 1'b1;
      idx    <= 0;
      total  <= 24 + ((length != 12'h000) ? 8 * length + 32 : 0);
    end else if (active && inReady) begin
      idx <= idx + 1;
      if (idx == total - 1) active <= 1'b0;
    end
  end

  // a released data line toggles so a stale bit is never mistaken for data
  assign inValid = active;
  assign inBit   = !active ? flip : (idx < 2) ? seedSelect[idx] : srcBit(idx);
  assign inLast  = active && (idx == 7 || idx == 15 || idx == 23);
endmodule

// ==== ofdm_tx_bit_encoder.sv ====
// transmit bit chain: header check word, payload unit framing, scrambler, encoder
// assumes the controller streams phy header, mac header, parity, payload and fcs bits in order
`timescale 1ns/1ps
`include "ofdm_tx_params.svh"

// Notes on behaviour
// - crc-16 guards phy and mac headers
// - send inverted crc remainder as check word
// - crc in transmit order, before scrambling
// - crc register preset to all ones
// - payload, fcs, six tails, then pad
// - payload tail bits sent unscrambled zero
// - zero length gives no payload unit
// - pad to multiple of info bits
// - pad zeros pass through the scrambler
// - scramble mac header and payload, reload seed
// - fifteen stage generator, taps fourteen, fifteen
// - output bit is data xor sequence
// - receiver loads same seed from selector
// - four seed values chosen by selector
// - selector resets zero, wraps per frame
// - consecutive frames share a seed only across a reset
// - header tails: six, six, four zeros
// - rate third, k seven, 133 165 171
// - outputs ordered a, b, c
// - final partial block gets partial pattern
// - header rate third; restart from zero
// - payload rate third, half, 5/8, 3/4
module ofdm_tx_bit_encoder
  import ofdm_tx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       cfgValid,
  output logic            cfgReady,
  input  wire frame_cfg_t cfg,
  input  wire logic       inValid,
  output logic            inReady,
  input  wire logic       inBit,
  input  wire logic       inLast,
  output logic            codedValid,
  input  wire logic       codedReady,
  output coded_t          codedData,
  output logic [1:0]      seedSelect,
  output logic            busy,
  output logic            frameDone
);

  // ==================================================
  // helpers
  // the same table serves a descrambler, which picks its seed from the received selector
  function automatic logic [14:0] seedValue(input logic [1:0] sel);
    unique case (sel)
      2'h0: seedValue = `SCR_SEED_0;
      2'h1: seedValue = `SCR_SEED_1;
      2'h2: seedValue = `SCR_SEED_2;
      2'h3: seedValue = `SCR_SEED_3;
    endcase
  endfunction

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
    crcStep = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `CRC_POLY : 16'h0000);
  endfunction

  // ==================================================
  // state
  tx_state_t   state;
  tx_state_t   next_state;
  frame_cfg_t  frameCfg;
  logic [14:0] cnt;
  logic [15:0] crc;
  logic [14:0] scr;
  logic [11:0] bitMod;

  // ==================================================
  // encoder handshake
  logic encReady;

  // ==================================================
  // state decoding
  wire logic isPhy       = (state == ST_PHY);
  wire logic isPhyTail   = (state == ST_PHY_TAIL);
  wire logic isMac       = (state == ST_MAC);
  wire logic isHcs       = (state == ST_HCS);
  wire logic isHcsTail   = (state == ST_HCS_TAIL);
  wire logic isParity    = (state == ST_PARITY);
  wire logic isParTail   = (state == ST_PARITY_TAIL);
  wire logic isPay       = (state == ST_PAY);
  wire logic isFcs       = (state == ST_FCS);
  wire logic isPayTail   = (state == ST_PAY_TAIL);
  wire logic isPad       = (state == ST_PAD);
  wire logic isIdle      = (state == ST_IDLE);
  wire logic isDone      = (state == ST_DONE);

  // states whose bits come from the controller
  wire logic fromInput   = isPhy | isMac | isParity | isPay | isFcs;
  // states whose bits are generated here
  wire logic padDone     = (bitMod == 12'h000);
  wire logic internal    = isPhyTail | isHcs | isHcsTail | isParTail | isPayTail | (isPad & ~padDone);
  wire logic inPsdu      = isPay | isFcs | isPayTail | isPad;

  // ==================================================
  // bit source selection
  // check word goes out msb first, matching the bit order the crc consumed
  wire logic rawBit      = fromInput ? inBit : (isHcs & ~crc[15]);
  // headers tails and the payload tail leave unscrambled; pad is whitened
  wire logic scrOn       = isMac | isHcs | inPsdu & ~isPayTail;
  // the tail still steps the sequence so pad bits see the right whitening
  wire logic scrAdvance  = scrOn | isPayTail;
  wire logic prbsBit     = scr[`SCR_TAP_14] ^ scr[`SCR_TAP_15];
  wire logic encBit      = rawBit ^ (scrOn & prbsBit);
  wire logic srcValid    = fromInput ? inValid : internal;
  wire logic fire        = srcValid & encReady;
  wire logic crcOn       = isPhy | isMac;

  // ==================================================
  // segment ends
  wire logic [14:0] payBits = {frameCfg.length, 3'b000};
  wire logic payLast     = (cnt == payBits - 15'h0001);
  wire logic tailLast    = (cnt == `TAIL_LAST);
  wire logic segEnd      = ((isPhy | isMac | isParity) & inLast)
                         | ((isPhyTail | isHcsTail | isPayTail) & tailLast)
                         | (isHcs & (cnt == `CRC_LAST))
                         | (isParTail & (cnt == `PARITY_TAIL_LAST))
                         | (isPay & payLast)
                         | (isFcs & (cnt == `FCS_LAST));
  wire logic advance     = fire & segEnd;
  wire logic encFirst    = (isPhy | isPay) & (cnt == 15'h0000);
  wire logic modLast     = (bitMod == frameCfg.infoBits - 12'h001);
  wire logic emptyPay    = (frameCfg.length == 12'h000);

  // ==================================================
  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:        if (cfgValid) next_state = ST_PHY;
      ST_PHY:         if (advance) next_state = ST_PHY_TAIL;
      ST_PHY_TAIL:    if (advance) next_state = ST_MAC;
      ST_MAC:         if (advance) next_state = ST_HCS;
      ST_HCS:         if (advance) next_state = ST_HCS_TAIL;
      ST_HCS_TAIL:    if (advance) next_state = ST_PARITY;
      ST_PARITY:      if (advance) next_state = ST_PARITY_TAIL;
      ST_PARITY_TAIL: begin
        if (advance) begin
          next_state = emptyPay ? ST_DONE : ST_PAY;
        end
      end
      ST_PAY:         if (advance) next_state = ST_FCS;
      ST_FCS:         if (advance) next_state = ST_PAY_TAIL;
      ST_PAY_TAIL:    if (advance) next_state = ST_PAD;
      // pad until the unit length is a multiple of the interleaver block
      ST_PAD:         if (padDone) next_state = ST_DONE;
      ST_DONE:        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==================================================
  // frame configuration capture
  always_ff @(posedge clk) begin
    if (!nrst) begin
      frameCfg <= '0;
    end else if (isIdle & cfgValid) begin
      frameCfg <= cfg;
    end
  end

  // ==================================================
  // segment bit counter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt <= 15'h0000;
    end else if (advance | isIdle) begin
      cnt <= 15'h0000;
    end else if (fire) begin
      cnt <= cnt + 15'h0001;
    end
  end

  // ==================================================
  // header check word
  always_ff @(posedge clk) begin
    if (!nrst) begin
      crc <= `CRC_INIT;
    end else if (isIdle) begin
      crc <= `CRC_INIT;
    end else if (fire & crcOn) begin
      crc <= crcStep(crc, inBit);
    end else if (fire & isHcs) begin
      crc <= {crc[14:0], 1'b0};
    end
  end

  // ==================================================
  // side-stream scrambler
  // loaded at frame accept (idle until the mac header) and again at payload start
  wire logic reloadPay = advance & isParTail;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scr <= `SCR_SEED_0;
    end else if ((isIdle & cfgValid) | reloadPay) begin
      scr <= seedValue(seedSelect);
    end else if (fire & scrAdvance) begin
      scr <= {scr[13:0], prbsBit};
    end
  end

  // ==================================================
  // seed selector
  // advancing once per frame means neighbours, retransmissions too, differ except across a reset, which returns the selector to zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      seedSelect <= 2'h0;
    end else if (isDone) begin
      seedSelect <= seedSelect + 2'h1;
    end
  end

  // ==================================================
  // interleaver boundary tracking
  // counts modulo infoBits, so no divider is needed; infoBits of zero is not supported
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bitMod <= 12'h000;
    end else if (reloadPay) begin
      bitMod <= 12'h000;
    end else if (fire & inPsdu) begin
      bitMod <= modLast ? 12'h000 : bitMod + 12'h001;
    end
  end

  // ==================================================
  // status
  always_ff @(posedge clk) begin
    if (!nrst) begin
      frameDone <= 1'b0;
    end else begin
      frameDone <= isDone;
    end
  end

  assign cfgReady = isIdle;
  assign busy     = ~isIdle;
  assign inReady  = fromInput & encReady;

  // ==================================================
  // encoder
  // header always at rate third, payload at the frame rate
  wire code_rate_t encRate = inPsdu ? frameCfg.rate : RATE_THIRD;

  conv_encoder_punct encoder (
    .clk       (clk),
    .nrst      (nrst),
    .rate      (encRate),
    .firstBit  (encFirst),
    .isPayload (inPsdu),
    .inValid   (srcValid),
    .inBit     (encBit),
    .inReady   (encReady),
    .outValid  (codedValid),
    .outReady  (codedReady),
    .outData   (codedData)
  );

endmodule

// ==== ofdm_tx_bit_encoder_bench.sv ====
// self-checking bench for the transmit bit encoder with a controller model
// assumes the package, header, design and controller model compile first
`timescale 1ns/1ps
`include "ofdm_tx_params.svh"

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("Error at %0t ns: got %0h expected %0h", $time, g, e); end end

module ofdm_tx_bit_encoder_bench
  import ofdm_tx_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cfgValid = 1'b0;
  frame_cfg_t  cfg = '0;
  logic        codedReady = 1'b1;
  logic        go = 1'b0;
  logic        stall = 1'b0;
  logic        inValid, inReady, inBit, inLast, cfgReady, codedValid, busy, frameDone;
  logic [1:0]  seedSelect;
  coded_t      codedData, want;
  coded_t      expQ[$];
  int          error_cnt = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          frameNo = 0;
  int          pos, plast;
  logic [15:0] crc;
  logic [14:0] sr, mask;
  logic [5:0]  st;
  logic [14:0] seeds [4] = '{15'h7ffc, 15'h7ffe, 15'h7ffd, 15'h7fff};

  initial forever #2 clk = ~clk;

  ofdm_tx_bit_encoder DUT (
    .clk(clk), .nrst(nrst), .cfgValid(cfgValid), .cfgReady(cfgReady), .cfg(cfg),
    .inValid(inValid), .inReady(inReady), .inBit(inBit), .inLast(inLast), .codedValid(codedValid),
    .codedReady(codedReady), .codedData(codedData), .seedSelect(seedSelect), .busy(busy), .frameDone(frameDone)
  );
  link_ctrl_model CTRL (
    .clk(clk), .nrst(nrst), .go(go), .length(cfg.length), .seedSelect(seedSelect),
    .inReady(inReady), .inValid(inValid), .inBit(inBit), .inLast(inLast)
  );

  // ==================================================
  // reference model of the source stream and encoder
  function automatic logic srcBit(input int k);
    return ((k * 7) % 5) > 1;
  endfunction

  task automatic crcBit(input logic b);
    crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? 16'h1021 : 16'h0000);
  endtask

  task automatic scrBit(inout logic b);
    logic x;
    x  = sr[13] ^ sr[14];
    b  = b ^ x;
    sr = {sr[13:0], x};
  endtask

  task automatic enc(input logic b, input logic pay);
    logic [6:0] w;
    coded_t     g;
    w         = {b, st};
    g.bits    = {^(w & 7'h79), ^(w & 7'h75), ^(w & 7'h5b)};
    g.keep    = pay ? mask[3 * pos +: 3] : 3'h7;
    g.payload = pay;
    st        = w[6:1];
    if (pay) pos = (pos == plast) ? 0 : pos + 1;
    expQ.push_back(g);
  endtask

  task automatic build_exp(input code_rate_t r, input int len, input int info, input logic [1:0] sel);
    logic b;
    int   n;
    crc = 16'hffff;
    st  = 6'h00;
    sr  = seeds[sel];
    for (int i = 0; i < 8; i++) begin
      b = (i < 2) ? sel[i] : srcBit(i);
      crcBit(b);
      enc(b, 1'b0);
    end
    repeat (6) enc(1'b0, 1'b0);
    for (int i = 8; i < 16; i++) begin
      b = srcBit(i);
      crcBit(b);
      scrBit(b);
      enc(b, 1'b0);
    end
    for (int i = 15; i >= 0; i--) begin
      b = ~crc[i];
      scrBit(b);
      enc(b, 1'b0);
    end
    repeat (6) enc(1'b0, 1'b0);
    for (int i = 16; i < 24; i++) enc(srcBit(i), 1'b0);
    repeat (4) enc(1'b0, 1'b0);
    if (len == 0) return;
    sr    = seeds[sel];
    st    = 6'h00;
    pos   = 0;
    mask  = (r == RATE_HALF) ? `PUNC_HALF_MASK : (r == RATE_FIVE_EIGHTHS) ? `PUNC_58_MASK :
            (r == RATE_THREE_QUARTERS) ? `PUNC_34_MASK : `PUNC_THIRD_MASK;
    plast = (r == RATE_HALF) ? `PUNC_HALF_LAST : (r == RATE_FIVE_EIGHTHS) ? `PUNC_58_LAST :
            (r == RATE_THREE_QUARTERS) ? `PUNC_34_LAST : `PUNC_THIRD_LAST;
    n = ((8 * len + 38 + info - 1) / info) * info;
    for (int i = 0; i < n; i++) begin
      b = (i < 8 * len + 32) ? srcBit(24 + i) : 1'b0;
      scrBit(b);
      if (i >= 8 * len + 32 && i < 8 * len + 38) b = 1'b0;
      enc(b, 1'b1);
    end
  endtask

  // ==================================================
  // output monitor and stall pattern
  always @(posedge clk) begin
    codedReady <= stall ? ~codedReady : 1'b1;
    if (nrst && codedValid === 1'b1 && codedReady) begin
      if (expQ.size() == 0) begin
        `CHK(codedValid, 1'b0)
      end else begin
        want = expQ.pop_front();
        `CHK(codedData, want)
      end
    end
  end

  // ==================================================
  // frame drivers
  task automatic start_frame(input code_rate_t r, input int len, input int info);
    int t;
    t = 0;
    while (cfgReady !== 1'b1 && t < 100) begin
      @(posedge clk);
      t++;
    end
    `CHK(seedSelect, frameNo[1:0])
    build_exp(r, len, info, frameNo[1:0]);
    cfgValid <= 1'b1;
    cfg      <= '{r, len[11:0], info[11:0]};
    go       <= 1'b1;
    @(posedge clk);
    cfgValid <= 1'b0;
    go       <= 1'b0;
  endtask

  task automatic finish_frame();
    int t;
    t = 0;
    while (frameDone !== 1'b1 && t < 3000) begin
      @(posedge clk);
      t++;
    end
    `CHK(frameDone, 1'b1)
    t = 0;
    while (expQ.size() != 0 && t < 50) begin
      @(posedge clk);
      t++;
    end
    `CHK(expQ.size(), 0)
    frameNo++;
  endtask

  // ==================================================
  // scenarios
  task automatic test_header_only();
    start_frame(RATE_THIRD, 0, 30);
    finish_frame();
    $display("test header_only done");
  endtask

  task automatic test_half_stalled();
    stall <= 1'b1;
    start_frame(RATE_HALF, 2, 30);
    finish_frame();
    stall <= 1'b0;
    $display("test half_stalled done");
  endtask

  task automatic test_58_no_pad();
    start_frame(RATE_FIVE_EIGHTHS, 1, 46);
    finish_frame();
    $display("test 58_no_pad done");
  endtask

  task automatic test_34_long_pad();
    start_frame(RATE_THREE_QUARTERS, 3, 100);
    finish_frame();
    $display("test 34_long_pad done");
  endtask

  task automatic test_seed_wrap();
    start_frame(RATE_THIRD, 1, 20);
    finish_frame();
    $display("test seed_wrap done");
  endtask

  task automatic test_reset_mid();
    start_frame(RATE_HALF, 4, 50);
    repeat (20) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    expQ.delete();
    frameNo = 0;
    @(posedge clk);
    `CHK(busy, 1'b0)
    start_frame(RATE_THIRD, 0, 30);
    finish_frame();
    $display("test reset_mid done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // a hung handshake ends the run here instead of stalling the simulator
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      $display("Error at %0t ns: run timed out", $time);
      complete_run();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    test_header_only();
    test_half_stalled();
    test_58_no_pad();
    test_34_long_pad();
    test_seed_wrap();
    test_reset_mid();
    complete_run();
  end
endmodule

// ==== ofdm_tx_bit_encoder_props.sv ====
// assertions on the bit encoder ports
// assumes a bind onto the encoder top, every port by name
`timescale 1ns/1ps

module ofdm_tx_bit_encoder_props
  import ofdm_tx_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       cfgValid,
  input wire logic       cfgReady,
  input wire frame_cfg_t cfg,
  input wire logic       inValid,
  input wire logic       inReady,
  input wire logic       inBit,
  input wire logic       inLast,
  input wire logic       codedValid,
  input wire logic       codedReady,
  input wire coded_t     codedData,
  input wire logic [1:0] seedSelect,
  input wire logic       busy,
  input wire logic       frameDone
);
  code_rate_t rateQ;
  logic       lenZero;

  // ==================================================
  // frame settings latched at accept
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rateQ   <= RATE_THIRD;
      lenZero <= 1'b0;
    end else if (cfgValid && cfgReady) begin
      rateQ   <= cfg.rate;
      lenZero <= cfg.length == 12'h000;
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==================================================
  // properties
  property p_reset_clear;
    $rose(nrst) |-> seedSelect == 2'h0 && !codedValid && !frameDone;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left outputs set");
  property p_seed_step;
    $rose(frameDone) |-> seedSelect == $past(seedSelect) + 2'h1;
  endproperty
  a_seed_step: assert property (p_seed_step) else $error("selector did not step by one");
  property p_seed_hold;
    !$stable(seedSelect) |-> frameDone;
  endproperty
  a_seed_hold: assert property (p_seed_hold) else $error("selector moved inside a frame");
  property p_header_keep;
    codedValid && !codedData.payload |-> codedData.keep == 3'h7;
  endproperty
  a_header_keep: assert property (p_header_keep) else $error("header group punctured");
  property p_third_keep;
    codedValid && codedData.payload && rateQ == RATE_THIRD |-> codedData.keep == 3'h7;
  endproperty
  a_third_keep: assert property (p_third_keep) else $error("third rate payload punctured");
  property p_a_kept;
    codedValid && codedData.payload |-> codedData.keep[0];
  endproperty
  a_a_kept: assert property (p_a_kept) else $error("first generator output dropped");
  property p_no_payload;
    codedValid && lenZero |-> !codedData.payload;
  endproperty
  a_no_payload: assert property (p_no_payload) else $error("payload bits in empty frame");
  property p_hold;
    codedValid && !codedReady |=> codedValid && $stable(codedData);
  endproperty
  a_hold: assert property (p_hold) else $error("coded group changed while stalled");
endmodule

bind ofdm_tx_bit_encoder ofdm_tx_bit_encoder_props props_i (
  .clk(clk), .nrst(nrst), .cfgValid(cfgValid), .cfgReady(cfgReady), .cfg(cfg),
  .inValid(inValid), .inReady(inReady), .inBit(inBit), .inLast(inLast), .codedValid(codedValid),
  .codedReady(codedReady), .codedData(codedData), .seedSelect(seedSelect), .busy(busy), .frameDone(frameDone)
);

// ==== ofdm_tx_params.svh ====
// constants for the transmit bit processing chain: crc, scrambler, code, counts
// assumes inclusion by the package user modules; definitions only
`ifndef OFDM_TX_PARAMS_SVH
`define OFDM_TX_PARAMS_SVH

// ==================================================
// header check word
`define CRC_POLY          16'h1021
`define CRC_INIT          16'hffff
`define CRC_LAST          15'h000f

// ==================================================
// scrambler seeds, bit 0 is the first delay stage
`define SCR_SEED_0        15'h7ffc
`define SCR_SEED_1        15'h7ffe
`define SCR_SEED_2        15'h7ffd
`define SCR_SEED_3        15'h7fff
`define SCR_TAP_14        13
`define SCR_TAP_15        14

// ==================================================
// segment lengths as last index of a zero based count
`define TAIL_LAST         15'h0005
`define PARITY_TAIL_LAST  15'h0003
`define FCS_LAST          15'h001f

// ==================================================
// convolutional generators, msb taps the current input
`define GEN_A             7'h5b
`define GEN_B             7'h75
`define GEN_C             7'h79

// ==================================================
// puncturing keep masks, bit 3*i+g keeps output g of input i in the block
`define PUNC_THIRD_MASK   15'h0007
`define PUNC_HALF_MASK    15'h0003
`define PUNC_58_MASK      15'h32cb
`define PUNC_34_MASK      15'h004b
`define PUNC_THIRD_LAST   3'h0
`define PUNC_HALF_LAST    3'h0
`define PUNC_58_LAST      3'h4
`define PUNC_34_LAST      3'h2

`endif

// ==== ofdm_tx_pkg.sv ====
// types shared by the transmit bit encoder and its convolutional stage
// assumes nothing beyond a SystemVerilog compiler
package ofdm_tx_pkg;

  typedef enum logic [1:0] {
    RATE_THIRD,
    RATE_HALF,
    RATE_FIVE_EIGHTHS,
    RATE_THREE_QUARTERS
  } code_rate_t;

  typedef struct packed {
    code_rate_t  rate;
    logic [11:0] length;
    logic [11:0] infoBits;
  } frame_cfg_t;

  typedef struct packed {
    logic [2:0] bits;
    logic [2:0] keep;
    logic       payload;
  } coded_t;

  typedef enum {
    ST_IDLE,
    ST_PHY,
    ST_PHY_TAIL,
    ST_MAC,
    ST_HCS,
    ST_HCS_TAIL,
    ST_PARITY,
    ST_PARITY_TAIL,
    ST_PAY,
    ST_FCS,
    ST_PAY_TAIL,
    ST_PAD,
    ST_DONE
  } tx_state_t;

endpackage
